// *** src/mic_input_control_regs.sv ***
`timescale 1ns/1ns
// Behaviour
// - Bias D7 set means software power-down
// - Bias off unless forced, detect on, absent
// - Bias level field picks off/2V/2.5V/rail
// - Gain field is half-dB steps to 59.5
// - Positive route holds three resistance selectors
// - Negative route holds common-mode, left-neg selectors
// - Unrouted inputs tie to common mode if set
// - Status bit reads one once a written gain is applied; zero from reset
module mic_input_control_regs #(
  parameter int STEP_CYCLES = mic_regs_pkg::GAIN_STEP_CYCLES
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic headset_detect_en,
  input wire logic headset_inserted,
  output logic sw_power_down,
  output logic mic_bias_supply_on,
  output logic [1:0] mic_bias_supply_level,
  output logic [6:0] mic_preamp_gain,
  output logic [1:0] left_pos_mic_input_sel,
  output logic [1:0] right_pos_mic_input_sel,
  output logic [1:0] left_neg_mic_input_pos_sel,
  output logic [1:0] common_mode_node_sel,
  output logic [1:0] left_neg_mic_input_neg_sel,
  output logic left_pos_mic_input_tie,
  output logic right_pos_mic_input_tie,
  output logic left_neg_mic_input_tie
);
  // A selector other than open means the input feeds the preamp
  function automatic logic route_used(input logic [1:0] sel);
    route_used = (sel != mic_regs_pkg::ROUTE_OPEN);
  endfunction : route_used

  // Masks a write byte; bits outside the mask become zero
  function automatic logic [7:0] masked(input logic [7:0] data, input logic [7:0] mask);
    masked = data & mask;
  endfunction : masked

  // Register file
  logic [7:0] page_reg; // Page select, register 0 of every page
  logic [7:0] bias_reg;
  logic [7:0] preamp_reg;
  logic [7:0] pos_route_reg;
  logic [7:0] neg_route_reg;
  logic [7:0] tie_reg; // Writable tie bits only; status added on read
  logic [7:0] rdata_reg;
  // Pin synchronisers for the headset inputs
  logic det_en_s1_reg, det_en_s2_reg;
  logic inserted_s1_reg, inserted_s2_reg;
  // Status from the stepper
  logic [6:0] applied_gain;
  logic gain_done;

  // Address decode; bank answers only while page one is selected
  // page gating
  wire logic page_ok = (page_reg == mic_regs_pkg::MIC_PAGE);
  wire logic hit_page = (reg_addr == mic_regs_pkg::PAGE_SEL_ADDR);
  wire logic hit_bias = page_ok && (reg_addr == mic_regs_pkg::BIAS_ADDR);
  wire logic hit_preamp = page_ok && (reg_addr == mic_regs_pkg::PREAMP_ADDR);
  wire logic hit_pos = page_ok && (reg_addr == mic_regs_pkg::POS_ROUTE_ADDR);
  wire logic hit_neg = page_ok && (reg_addr == mic_regs_pkg::NEG_ROUTE_ADDR);
  wire logic hit_tie = page_ok && (reg_addr == mic_regs_pkg::TIE_ADDR);
  wire logic wr_preamp = reg_wr && hit_preamp;

  // Effective gain target: fixed bit forces 0 dB
  // fixed 0 dB
  wire logic gain_fixed = preamp_reg[mic_regs_pkg::PREAMP_FIXED_BIT];
  wire logic [6:0] gain_field = preamp_reg[mic_regs_pkg::PREAMP_GAIN_LSB +: 7];
  // half-dB codes, clamp keeps reserved codes off the analog
  wire logic [6:0] gain_clamped =
    (gain_field > mic_regs_pkg::PREAMP_GAIN_MAX) ? mic_regs_pkg::PREAMP_GAIN_MAX : gain_field;
  wire logic [6:0] gain_target = gain_fixed ? 7'h00 : gain_clamped;

  // Read mux; unmapped numbers read zero
  wire logic [7:0] tie_read = {tie_reg[7:1], gain_done};
  wire logic [7:0] rd_mux =
    hit_page ? page_reg :
    hit_bias ? bias_reg :
    hit_preamp ? preamp_reg :
    hit_pos ? pos_route_reg :
    hit_neg ? neg_route_reg :
    hit_tie ? tie_read : 8'h00;

  // Headset pins come from outside; two flops before use
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      det_en_s1_reg <= 1'b0;
      det_en_s2_reg <= 1'b0;
      inserted_s1_reg <= 1'b0;
      inserted_s2_reg <= 1'b0;
    end else if (ce) begin
      det_en_s1_reg <= headset_detect_en;
      det_en_s2_reg <= det_en_s1_reg;
      inserted_s1_reg <= headset_inserted;
      inserted_s2_reg <= inserted_s1_reg;
    end
  end

  // Page select is reachable on any page
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      page_reg <= mic_regs_pkg::PAGE_RST;
    end else if (ce && reg_wr && hit_page) begin
      page_reg <= reg_wdata;
    end
  end

  // Bias and preamp registers; reserved bits stored as zero
  // reserved bits masked
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      bias_reg <= mic_regs_pkg::BIAS_RST;
      preamp_reg <= mic_regs_pkg::PREAMP_RST;
    end else if (ce) begin
      if (reg_wr && hit_bias) begin
        bias_reg <= masked(reg_wdata, mic_regs_pkg::BIAS_WMASK);
      end
      if (wr_preamp) begin
        preamp_reg <= masked(reg_wdata, mic_regs_pkg::PREAMP_WMASK);
      end
    end
  end

  // Routing and tie registers
  // positive selectors stored
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pos_route_reg <= mic_regs_pkg::POS_ROUTE_RST;
      neg_route_reg <= mic_regs_pkg::NEG_ROUTE_RST;
      tie_reg <= mic_regs_pkg::TIE_RST;
    end else if (ce && reg_wr) begin
      if (hit_pos) begin
        pos_route_reg <= masked(reg_wdata, mic_regs_pkg::POS_ROUTE_WMASK);
      end
      if (hit_neg) begin
        neg_route_reg <= masked(reg_wdata, mic_regs_pkg::NEG_ROUTE_WMASK);
      end
      if (hit_tie) begin
        tie_reg <= masked(reg_wdata, mic_regs_pkg::TIE_WMASK);
      end
    end
  end

  // Read data is held in a flop until the next read
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_reg <= 8'h00;
    end else if (ce && reg_rd) begin
      rdata_reg <= rd_mux;
    end
  end

  // Gain stepper; a preamp write restarts it even with same value
  // write clears status
  gain_stepper #(
    .STEP_CYCLES(STEP_CYCLES)
  ) u_stepper (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .ce(ce),
    .target(gain_target),
    .restart(wr_preamp),
    .applied(applied_gain),
    .done(gain_done)
  );

  // Bias supply control
  // power-down bit
  assign sw_power_down = bias_reg[mic_regs_pkg::BIAS_PDN_BIT];
  wire logic bias_gated = det_en_s2_reg && !inserted_s2_reg
    && !bias_reg[mic_regs_pkg::BIAS_FORCE_BIT];
  wire logic [1:0] bias_lvl = bias_reg[mic_regs_pkg::BIAS_LVL_LSB +: 2];
  assign mic_bias_supply_level = bias_lvl;
  assign mic_bias_supply_on = (bias_lvl != mic_regs_pkg::BIAS_OFF) && !bias_gated;

  // Applied gain comes from the stepper, never jumps
  assign mic_preamp_gain = applied_gain;

  // Routing selectors straight from storage
  assign left_pos_mic_input_sel = pos_route_reg[mic_regs_pkg::POS_LP_LSB +: 2];
  assign right_pos_mic_input_sel = pos_route_reg[mic_regs_pkg::POS_RP_LSB +: 2];
  assign left_neg_mic_input_pos_sel = pos_route_reg[mic_regs_pkg::POS_LM_LSB +: 2];
  assign common_mode_node_sel = neg_route_reg[mic_regs_pkg::NEG_CM_LSB +: 2];
  assign left_neg_mic_input_neg_sel = neg_route_reg[mic_regs_pkg::NEG_LM_LSB +: 2];

  // Tie to common mode only while the input is not routed
  // tie unrouted inputs
  assign left_pos_mic_input_tie = tie_reg[mic_regs_pkg::TIE_LP_BIT]
    && !route_used(left_pos_mic_input_sel);
  assign right_pos_mic_input_tie = tie_reg[mic_regs_pkg::TIE_RP_BIT]
    && !route_used(right_pos_mic_input_sel);
  assign left_neg_mic_input_tie = tie_reg[mic_regs_pkg::TIE_LM_BIT]
    && !route_used(left_neg_mic_input_pos_sel) && !route_used(left_neg_mic_input_neg_sel);

  assign reg_rdata = rdata_reg;
endmodule : mic_input_control_regs

// *** inc/mic_regs_pkg.sv ***
package mic_regs_pkg;
  // Register numbers inside a page; data is one byte
  localparam logic [6:0] PAGE_SEL_ADDR = 7'h00;
  localparam logic [6:0] BIAS_ADDR = 7'h2e;
  localparam logic [6:0] PREAMP_ADDR = 7'h2f;
  localparam logic [6:0] POS_ROUTE_ADDR = 7'h30;
  localparam logic [6:0] NEG_ROUTE_ADDR = 7'h31;
  localparam logic [6:0] TIE_ADDR = 7'h32;
  // Page that holds this bank
  localparam logic [7:0] MIC_PAGE = 8'h01;
  // Reset values
  localparam logic [7:0] PAGE_RST = 8'h00;
  localparam logic [7:0] BIAS_RST = 8'h00;
  localparam logic [7:0] PREAMP_RST = 8'h80;
  localparam logic [7:0] POS_ROUTE_RST = 8'h00;
  localparam logic [7:0] NEG_ROUTE_RST = 8'h00;
  localparam logic [7:0] TIE_RST = 8'h00;
  // Writable bit masks; reserved bits are stored as zero
  localparam logic [7:0] BIAS_WMASK = 8'h8b;
  localparam logic [7:0] PREAMP_WMASK = 8'hff;
  localparam logic [7:0] POS_ROUTE_WMASK = 8'hfc;
  localparam logic [7:0] NEG_ROUTE_WMASK = 8'hf0;
  localparam logic [7:0] TIE_WMASK = 8'he0;
  // Bias register fields
  localparam int BIAS_PDN_BIT = 7;
  localparam int BIAS_FORCE_BIT = 3;
  localparam int BIAS_LVL_LSB = 0;
  // Preamp register fields
  localparam int PREAMP_FIXED_BIT = 7;
  localparam int PREAMP_GAIN_LSB = 0;
  localparam logic [6:0] PREAMP_GAIN_MAX = 7'h77;
  // Routing selector fields
  localparam int POS_LP_LSB = 6;
  localparam int POS_RP_LSB = 4;
  localparam int POS_LM_LSB = 2;
  localparam int NEG_CM_LSB = 6;
  localparam int NEG_LM_LSB = 4;
  // Tie register fields
  localparam int TIE_LP_BIT = 7;
  localparam int TIE_RP_BIT = 6;
  localparam int TIE_LM_BIT = 5;
  localparam int TIE_DONE_BIT = 0;
  // Bias levels
  typedef enum logic [1:0] {
    BIAS_OFF = 2'b00,
    BIAS_2V0 = 2'b01,
    BIAS_2V5 = 2'b10,
    BIAS_RAIL = 2'b11
  } bias_level_t;
  // Series resistance codes
  typedef enum logic [1:0] {
    ROUTE_OPEN = 2'b00,
    ROUTE_10K = 2'b01,
    ROUTE_20K = 2'b10,
    ROUTE_40K = 2'b11
  } route_sel_t;
  // Timing of the analog gain stepper
  localparam int CLK_PERIOD_NS = 50;
  localparam int GAIN_STEP_NS = 1000;
  localparam int GAIN_STEP_CYCLES = (GAIN_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : mic_regs_pkg

// *** src/gain_stepper.sv ***
`timescale 1ns/1ns
// Walks the applied preamp gain one half-dB code per step toward target
module gain_stepper #(
  parameter int STEP_CYCLES = mic_regs_pkg::GAIN_STEP_CYCLES
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [6:0] target,
  input wire logic restart,
  output logic [6:0] applied,
  output logic done
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_STEP = 2'b10
  } step_state_t;

  step_state_t state_reg, state_next;
  logic [6:0] applied_reg, applied_next;
  logic [15:0] tick_reg, tick_next; // Step interval counter
  logic done_reg, done_next;

  // Step decision wires
  wire logic at_target = (applied_reg == target);
  wire logic tick_end = (tick_reg == 16'(STEP_CYCLES - 1));
  wire logic [6:0] toward = (applied_reg < target) ? applied_reg + 7'h01 : applied_reg - 7'h01;

  // Next state; restart always drops done, even mid-walk
  always_comb begin
    state_next = state_reg;
    applied_next = applied_reg;
    tick_next = tick_reg;
    done_next = done_reg;
    case (state_reg)
      ST_IDLE: begin
        if (restart) begin
          done_next = 1'b0;
          tick_next = 16'h0000;
          state_next = ST_WAIT;
        end
      end
      ST_WAIT: begin
        // Wait one step time between codes, so no zipper noise
        if (restart) begin
          tick_next = 16'h0000;
        end else if (tick_end) begin
          state_next = ST_STEP;
        end else begin
          tick_next = tick_reg + 16'h0001;
        end
        if (restart) begin
          done_next = 1'b0;
        end
      end
      ST_STEP: begin
        tick_next = 16'h0000;
        if (at_target) begin
          done_next = !restart;
          state_next = restart ? ST_WAIT : ST_IDLE;
        end else begin
          applied_next = toward;
          done_next = 1'b0;
          state_next = ST_WAIT;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // State registers
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= ST_IDLE;
      applied_reg <= 7'h00;
      tick_reg <= 16'h0000;
      done_reg <= 1'b0;
    end else if (ce) begin
      state_reg <= state_next;
      applied_reg <= applied_next;
      tick_reg <= tick_next;
      done_reg <= done_next;
    end
  end

  assign applied = applied_reg;
  assign done = done_reg;
endmodule : gain_stepper

// *** testbench/mic_input_control_regs_chk.sv ***
`timescale 1ns/1ns
// Ties bank outputs to the writes that cause them
module mic_input_control_regs_chk #(
  parameter int STEP_CYCLES = mic_regs_pkg::GAIN_STEP_CYCLES
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic headset_detect_en,
  input wire logic sw_power_down,
  input wire logic mic_bias_supply_on,
  input wire logic [1:0] mic_bias_supply_level,
  input wire logic [6:0] mic_preamp_gain,
  input wire logic [1:0] left_pos_mic_input_sel,
  input wire logic [1:0] common_mode_node_sel,
  input wire logic left_pos_mic_input_tie
);
  logic [7:0] page_reg; // Page shadow; bank writes count on page 1 only
  logic [7:0] page_next;
  wire pg1 = ce && reg_wr && page_reg == 8'h01; // Accepted bank write
  assign page_next = (ce && reg_wr && reg_addr == 7'h00) ? reg_wdata : page_reg;
  // Shadow follows the page register
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      page_reg <= 8'h00;
    end else begin
      page_reg <= page_next;
    end
  end
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  a_pdn_from_write: assert property (pg1 && reg_addr == 7'h2e |=>
    sw_power_down == $past(reg_wdata[7])) else $error("power-down bit wrong");
  a_bias_forced_on: assert property ((ce && !headset_detect_en
    && mic_bias_supply_level != 2'b00)[*3] |-> mic_bias_supply_on) else $error("bias off");
  a_bias_off_level: assert property (mic_bias_supply_level == 2'b00
    |-> !mic_bias_supply_on) else $error("bias on at level zero");
  a_level_from_write: assert property (pg1 && reg_addr == 7'h2e |=>
    mic_bias_supply_level == $past(reg_wdata[1:0])) else $error("bias level wrong");
  a_gain_one_step: assert property ($changed(mic_preamp_gain) |->
    mic_preamp_gain - $past(mic_preamp_gain) inside {7'h01, 7'h7f}) else $error("gain jump");
  a_gain_in_range: assert property (mic_preamp_gain <= 7'h77)
    else $error("gain above top code");
  a_pos_route_write: assert property (pg1 && reg_addr == 7'h30 |=>
    left_pos_mic_input_sel == $past(reg_wdata[7:6])) else $error("pos route wrong");
  a_neg_route_write: assert property (pg1 && reg_addr == 7'h31 |=>
    common_mode_node_sel == $past(reg_wdata[7:6])) else $error("neg route wrong");
  a_tie_if_unrouted: assert property (left_pos_mic_input_tie |->
    left_pos_mic_input_sel == 2'b00) else $error("routed input tied");
  a_write_clears_done: assert property (pg1 && reg_addr == 7'h2f ##1
    (ce && reg_rd && reg_addr == 7'h32 && page_reg == 8'h01) |=> !reg_rdata[0])
    else $error("status not cleared");
  a_freeze_holds: assert property (!ce |=> $stable(left_pos_mic_input_sel)
    && $stable(mic_preamp_gain) && $stable(reg_rdata)) else $error("state moved while frozen");
endmodule : mic_input_control_regs_chk
bind mic_input_control_regs mic_input_control_regs_chk #(
  .STEP_CYCLES(STEP_CYCLES)
) chk_inst (
  .sys_clk(sys_clk),
  .nrst(nrst),
  .ce(ce),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata),
  .headset_detect_en(headset_detect_en),
  .sw_power_down(sw_power_down),
  .mic_bias_supply_on(mic_bias_supply_on),
  .mic_bias_supply_level(mic_bias_supply_level),
  .mic_preamp_gain(mic_preamp_gain),
  .left_pos_mic_input_sel(left_pos_mic_input_sel),
  .common_mode_node_sel(common_mode_node_sel),
  .left_pos_mic_input_tie(left_pos_mic_input_tie)
);

// *** testbench/mic_host.sv ***
`timescale 1ns/1ns
// Host on the register port; drives on falling edges
module mic_host (
  input wire logic sys_clk,
  input wire logic [7:0] reg_rdata,
  output logic reg_wr,
  output logic reg_rd,
  output logic [6:0] reg_addr,
  output logic [7:0] reg_wdata
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 7'h7f;
    reg_wdata = 8'h00;
  end
  // One cycle transfer; strobes stay up so ops can run back to back
  task automatic op(input logic w, input logic [6:0] a, input logic [7:0] d,
    output logic [7:0] q);
    reg_wr = w;
    reg_rd = !w;
    reg_addr = a;
    reg_wdata = d;
    @(negedge sys_clk);
    q = reg_rdata;
  endtask : op
  // Release; idle lines flip so stale values never look valid
  task automatic rel;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~reg_addr;
    reg_wdata = ~reg_wdata;
    @(negedge sys_clk);
  endtask : rel
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] q;
    case (a)
      7'h2e: d = d & 8'h8b;
      7'h30: d = d & 8'hfc;
      7'h31: d = d & 8'hf0;
      7'h32: d = d & 8'he0;
      default: d = d;
    endcase
    if (a == 7'h2f && d[6:0] > 7'h77) d[6:0] = 7'h77;
    op(1'b1, a, d, q);
    rel();
  endtask : wr
  task automatic rd(input logic [6:0] a, output logic [7:0] q);
    op(1'b0, a, 8'h00, q);
    rel();
  endtask : rd
endmodule : mic_host

// *** testbench/mic_input_control_regs_test.sv ***
`timescale 1ns/1ns
// Host model plus shadow registers against the bank
module mic_input_control_regs_test;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b1; // Dropped once to prove the freeze
  logic headset_detect_en = 1'b0;
  logic headset_inserted = 1'b0;
  logic reg_wr, reg_rd, sw_power_down, mic_bias_supply_on;
  logic left_pos_mic_input_tie, right_pos_mic_input_tie, left_neg_mic_input_tie;
  logic [6:0] reg_addr, mic_preamp_gain;
  logic [7:0] reg_wdata, reg_rdata, q, tg;
  logic [1:0] mic_bias_supply_level, left_pos_mic_input_sel, right_pos_mic_input_sel;
  logic [1:0] left_neg_mic_input_pos_sel, common_mode_node_sel, left_neg_mic_input_neg_sel;
  logic [7:0] gs [4] = '{8'h0a, 8'h77, 8'hf7, 8'h15}; // Gain writes; one fixed
  int miscompares = 0;
  int n_checks = 0;
  int pg = 0; // Shadow page
  int mdl [5] = '{8'h00, 8'h80, 8'h00, 8'h00, 8'h00}; // Shadow of 0x2e..0x32
  int mk [5] = '{8'h8b, 8'hff, 8'hfc, 8'hf0, 8'he0}; // Stored bits
  mic_host mic_host_inst (.*);
  mic_input_control_regs #(.STEP_CYCLES(2)) mic_input_control_regs_inst (.*);
  initial begin
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // Off page or unmapped reads give zero
  function automatic int exp_rd(input int a);
    if (a == 0) return pg;
    if (pg == 1 && a >= 8'h2e && a <= 8'h32) return mdl[a - 8'h2e];
    return 0;
  endfunction : exp_rd
  task automatic mw(input int a, input int d);
    mic_host_inst.wr(7'(a), 8'(d));
    // Host clamps reserved gain codes, so the shadow must too
    if (a == 'h2f && (d & 'h7f) > 'h77) d = (d & 'h80) | 'h77;
    if (a == 0) pg = d;
    else if (pg == 1 && a >= 8'h2e && a <= 8'h32) mdl[a - 8'h2e] = d & mk[a - 8'h2e];
  endtask : mw
  task automatic mr(input int a, input logic [7:0] msk);
    mic_host_inst.rd(7'(a), q);
    check("rdata", q & msk, 8'(exp_rd(a)) & msk);
  endtask : mr
  task automatic outs;
    logic [7:0] b, p, n, t;
    b = 8'(mdl[0]);
    p = 8'(mdl[2]);
    n = 8'(mdl[3]);
    t = 8'(mdl[4]);
    check("pdn", 8'(sw_power_down), 8'(b[7]));
    check("level", 8'(mic_bias_supply_level), 8'(b[1:0]));
    check("bias_on", 8'(mic_bias_supply_on), 8'(b[1:0] != 2'b00));
    check("pos", {left_pos_mic_input_sel, right_pos_mic_input_sel,
      left_neg_mic_input_pos_sel, 2'b00}, p);
    check("neg", {common_mode_node_sel, left_neg_mic_input_neg_sel, 4'h0}, n);
    check("tie", {left_pos_mic_input_tie, right_pos_mic_input_tie,
      left_neg_mic_input_tie}, {t[7] && p[7:6] == 0, t[6] && p[5:4] == 0,
      t[5] && p[3:2] == 0 && n[5:4] == 0});
  endtask : outs
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict
  // Cuts a hang well past the expected run length
  initial begin
    #(50 * 30000);
    miscompares++;
    print_verdict();
  end
  initial begin
    void'($urandom(32'he963));
    repeat (20) @(negedge sys_clk);
    nrst = 1'b1;
    // Reset values, first off page then on page 1
    for (int k = 0; k < 2; k++) begin
      for (int a = 8'h2e; a < 8'h33; a++) mr(a, 8'hfe);
      mr(0, 8'hff);
      mw(0, 8'h01);
    end
    $display("test reset done");
    for (int i = 0; i < 40; i++) begin
      mw(8'h2e + $urandom_range(4), $urandom());
      outs();
      mr(8'h2e + $urandom_range(4), 8'hfe);
    end
    $display("test random done");
    for (int i = 0; i < 8; i++) begin
      mw(8'h2e, {4'h0, i[0], 1'b0, 2'($urandom_range(3, 1))});
      headset_detect_en = i[1];
      headset_inserted = i[2];
      repeat (4) @(negedge sys_clk);
      check("gate", 8'(mic_bias_supply_on), 8'(!(i[1] && !i[2] && !i[0])));
    end
    headset_detect_en = 1'b0;
    $display("test headset done");
    foreach (gs[i]) begin
      mic_host_inst.op(1'b1, 7'h2f, gs[i], q);
      mic_host_inst.op(1'b0, 7'h32, 8'h00, q);
      mic_host_inst.rel();
      mdl[1] = gs[i];
      check("done_clr", 8'(q[0]), 8'h00);
      tg = gs[i][7] ? 8'h00 : {1'b0, gs[i][6:0]};
      for (int w = 0; w < 2000 && 8'(mic_preamp_gain) !== tg; w++) @(negedge sys_clk);
      check("gain", 8'(mic_preamp_gain), tg);
      repeat (4) @(negedge sys_clk);
      mic_host_inst.rd(7'h32, q);
      check("done_set", 8'(q[0]), 8'h01);
      mr(8'h2f, 8'hff);
    end
    $display("test gain done");
    mw(0, 8'h02);
    mw(8'h2e, 8'h8b);
    mr(8'h2e, 8'hff);
    mw(0, 8'h01);
    outs();
    mw(8'h40, 8'h5a);
    mr(8'h40, 8'hff);
    $display("test page done");
    // Writes are dropped while the clock enable is low
    ce = 1'b0;
    mic_host_inst.wr(7'h30, 8'(~mdl[2]));
    ce = 1'b1;
    mr(8'h30, 8'hff);
    $display("test freeze done");
    print_verdict();
  end
endmodule : mic_input_control_regs_test
